// file: hdl/dma_transfer_signalling.sv
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "dma_cfg.svh"
// What this block does
// - Upper modifier bit high on single-address DMA cycles, else low
// - Lower modifier bits carry channel code 0 or 1; code 11 never
// - Per-channel select: indication on every transfer or last only
// - Modifier enabled, acks off: three modifier bits; disabled: port bits
// - Upper modifier bit still driven while acks are enabled
// - Channel-1 ack replaces modifier bit 1 when enabled
// - Channel-0 ack replaces modifier bit 0 when enabled
// - Byte counters are 24 bits on all channels, no width select
// - Four channels, each programmed individually; channels 2 and 3 take on-chip requests and no single-address
// - No single-address transfers with on-chip peripherals
// - Request from software start bit or external request pin
// - Cycle-steal and continuous modes, per-channel bandwidth
// - 32-bit addresses and data for both transfer kinds
// - Dual-address transfer is source read then destination write
// - Single-address: device gives address, external part moves data
// - Load, transfer, terminate with outcome in status register
// - Transfer-type pins show 01 on DMA cycles
// - Count drops by 1, 2, 4 or 16 after write or single access
module dma_transfer_signalling (
   input wire logic clk_i, // System clock
   input wire logic reset_i, // Async reset, active high
   input wire logic [9:0] paddr_i, // APB address
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB direction
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error
   output dma_pkg::bus_req_t bus_req_o, // System bus request
   input wire dma_pkg::bus_rsp_t bus_rsp_i, // System bus answer
   input wire logic [1:0] dma_request_in_n_i, // External requests, pins
   input wire logic [1:0] periph_req_i, // On-chip requests, ch 2 and 3
   input wire dma_pkg::pin_drv_t parallel_port_bits_i, // Port drive
   output dma_pkg::pin_drv_t transfer_modifier_bits_o, // Shared pins
   output logic [1:0] transfer_type_pins_o // Transfer type
);
   import dma_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic [31:0] sar_q [`NCH];
   logic [31:0] dar_q [`NCH];
   logic [15:0] dcr_q [`NCH];
   logic [`CNT_W-1:0] bcr_q [`NCH];
   logic [31:0] buf_q [4];
   logic [3:0] done_q, ce_q, be_q, run_q, req_q;
   logic [2:0] par_q;
   logic [1:0] interrupt_pin_assignment_q;
   logic [31:0] prdata_q;
   logic [1:0] rq_s1_q, rq_s2_q, rq_s3_q, rq_lvl_q, pr_q;
   eng_state_t state_q, state_d;
   logic [1:0] ch_q, ch_d, beat_q, beat_d;
   logic [7:0] gap_q, gap_d;
   bus_req_t breq_q, breq_d;
   logic xfer_ok, term_err, start_bad, start_zero;
   logic [1:0] sel;
   logic [31:0] dsr_v;

   function automatic logic [`CNT_W-1:0] step_of(input logic [1:0] sz);
      case (sz)
         `SZ_BYTE: step_of = `STEP_BYTE;
         `SZ_WORD: step_of = `STEP_WORD;
         `SZ_LONG: step_of = `STEP_LONG;
         default: step_of = `STEP_LINE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Register access
   wire setup = psel_i & ~penable_i;
   wire acc = psel_i & penable_i;
   wire [1:0] ch_a = paddr_i[7:6];
   wire [3:0] reg_a = paddr_i[5:2];
   wire ch_hit = (paddr_i[9:8] == `CH_REGION) && (reg_a <= `REG_DSR)
      && (paddr_i[1:0] == 2'h0);
   wire hit_par = paddr_i == `OFF_PAR;
   wire hit_irq = paddr_i == `OFF_INTERRUPT_PIN_ASSIGNMENT;
   wire mapped = ch_hit | hit_par | hit_irq;
   wire wr = acc & pwrite_i & mapped;
   wire wr_ch = wr & ch_hit;
   wire [3:0] acc_oh = 4'h1 << ch_a;
   wire [3:0] wr_sar = {4{wr_ch && reg_a == `REG_SAR}} & acc_oh;
   wire [3:0] wr_dar = {4{wr_ch && reg_a == `REG_DAR}} & acc_oh;
   wire [3:0] wr_dcr = {4{wr_ch && reg_a == `REG_DCR}} & acc_oh;
   wire [3:0] wr_bcr = {4{wr_ch && reg_a == `REG_BCR}} & acc_oh;
   wire [3:0] wr_dsr = {4{wr_ch && reg_a == `REG_DSR}} & acc_oh;
   wire [3:0] sw_start = wr_dcr & {4{pwdata_i[`CHANNEL_START_BIT]}};
   wire [3:0] st_clr = wr_dsr & {4{pwdata_i[`DSR_DONE]}};

   always_comb
   begin
      dsr_v = 32'h00000000;
      dsr_v[`DSR_DONE] = done_q[ch_a];
      dsr_v[`DSR_BSY] = run_q[ch_a];
      dsr_v[`DSR_CE] = ce_q[ch_a];
      dsr_v[`DSR_BE] = be_q[ch_a];
   end

   wire [31:0] ch_rd =
      (reg_a == `REG_SAR) ? sar_q[ch_a] :
      (reg_a == `REG_DAR) ? dar_q[ch_a] :
      (reg_a == `REG_DCR) ? {16'h0000, dcr_q[ch_a]} :
      (reg_a == `REG_BCR) ? {8'h00, bcr_q[ch_a]} : dsr_v;
   wire [31:0] rd_mux = ch_hit ? ch_rd :
      hit_par ? {29'h00000000, par_q} :
      hit_irq ? {30'h00000000, interrupt_pin_assignment_q} : 32'h00000000;

   assign pready_o = 1'b1;
   assign pslverr_o = acc & ~mapped;
   assign prdata_o = prdata_q;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         prdata_q <= 32'h00000000;
      else if (setup)
         prdata_q <= rd_mux;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         par_q <= 3'h0;
         interrupt_pin_assignment_q <= 2'h0;
      end
      else
      begin
         if (wr & hit_par)
            par_q <= pwdata_i[2:0];
         if (wr & hit_irq)
            interrupt_pin_assignment_q <= pwdata_i[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Request inputs; pins idle high, so reset to the idle level
   wire [1:0] rq_agree = ~(rq_s2_q ^ rq_s3_q);
   wire [1:0] rq_lvl_d = (rq_agree & rq_s3_q) | (~rq_agree & rq_lvl_q);
   wire [1:0] ext_fall = rq_lvl_q & ~rq_lvl_d;
   wire [1:0] per_rise = periph_req_i & ~pr_q;
   logic [3:0] eext;
   always_comb
   begin
      for (int c = 0; c < `NCH; c++)
         eext[c] = dcr_q[c][`DCR_EEXT];
   end
   wire [3:0] trig = {per_rise, ext_fall} & eext;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rq_s1_q <= `RQ_IDLE;
         rq_s2_q <= `RQ_IDLE;
         rq_s3_q <= `RQ_IDLE;
         rq_lvl_q <= `RQ_IDLE;
         pr_q <= 2'h0;
      end
      else
      begin
         rq_s1_q <= dma_request_in_n_i;
         rq_s2_q <= rq_s1_q;
         rq_s3_q <= rq_s2_q;
         rq_lvl_q <= rq_lvl_d;
         pr_q <= periph_req_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Arbitration, lowest channel first, only between transfers
   always_comb
   begin
      sel = 2'h0;
      for (int c = `NCH - 1; c >= 0; c--)
         if (req_q[c])
            sel = 2'(c);
   end
   wire any_req = |req_q;
   wire [15:0] sdcr = dcr_q[sel];
   wire [`CNT_W-1:0] sbcr = bcr_q[sel];
   wire [1:0] ssz = sdcr[`DCR_SIZE];
   wire sel_zero = sbcr == 24'h000000;
   wire sel_bad = (ssz == `SZ_LINE && sbcr[3:0] != 4'h0)
      || (ssz == `SZ_LONG && sbcr[1:0] != 2'h0)
      || (ssz == `SZ_WORD && sbcr[0])
      || (sel[1] && sdcr[`DCR_SAA]);

   wire [15:0] cdcr = dcr_q[ch_q];
   wire [`CNT_W-1:0] cstep = step_of(cdcr[`DCR_SIZE]);
   wire [`CNT_W-1:0] new_bcr = bcr_q[ch_q] - cstep;
   wire blk_end = new_bcr == 24'h000000;
   wire cs_mode = cdcr[`DCR_CS];
   wire beat_ok = breq_q.valid & bus_rsp_i.ready;
   wire last_beat = (cdcr[`DCR_SIZE] != `SZ_LINE) || (beat_q == `LINE_LAST);

   always_comb
   begin
      state_d = state_q;
      ch_d = ch_q;
      beat_d = beat_q;
      gap_d = gap_q;
      xfer_ok = 1'b0;
      term_err = 1'b0;
      start_bad = 1'b0;
      start_zero = 1'b0;
      case (state_q)
         S_IDLE:
            if (any_req)
            begin
               ch_d = sel;
               beat_d = 2'h0;
               if (sel_zero)
                  start_zero = 1'b1;
               else if (sel_bad)
                  start_bad = 1'b1;
               else if (sdcr[`DCR_SAA])
                  state_d = S_SA;
               else
                  state_d = S_RD;
            end
         S_RD, S_WR, S_SA:
            if (beat_ok)
            begin
               if (bus_rsp_i.err)
               begin
                  term_err = 1'b1;
                  state_d = S_IDLE;
               end
               else if (!last_beat)
                  beat_d = beat_q + 2'h1;
               else if (state_q == S_RD)
               begin
                  state_d = S_WR;
                  beat_d = 2'h0;
               end
               else
               begin
                  xfer_ok = 1'b1;
                  gap_d = {cdcr[`DCR_BWC], `BW_PAD};
                  // Bandwidth gap only between units of one block
                  if (!blk_end && !cs_mode && gap_d != 8'h00)
                     state_d = S_GAP;
                  else
                     state_d = S_IDLE;
               end
            end
         S_GAP:
            if (gap_q == 8'h00)
               state_d = S_IDLE;
            else
               gap_d = gap_q - 8'h01;
         default:
            state_d = S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Next bus request, held in flops until the bus answers
   wire [15:0] ddcr = dcr_q[ch_d];
   wire [`CNT_W-1:0] dstep = step_of(ddcr[`DCR_SIZE]);
   wire d_acc = state_d == S_RD || state_d == S_WR || state_d == S_SA;
   wire [31:0] d_base = (state_d == S_WR) ? dar_q[ch_d] : sar_q[ch_d];
   // Word of a single-beat read goes straight to the write, buffer not yet loaded;
   // only on the answering edge, so a stalled request holds its data
   wire fwd = state_q == S_RD && beat_ok && beat_q == beat_d;

   always_comb
   begin
      breq_d.valid = d_acc;
      breq_d.write = state_d == S_WR
         || (state_d == S_SA && ddcr[`DCR_SDIR]);
      breq_d.size = ddcr[`DCR_SIZE];
      breq_d.addr = d_base + {28'h0000000, beat_d, 2'h0};
      breq_d.wdata = fwd ? bus_rsp_i.rdata : buf_q[beat_d];
      breq_d.chan = ch_d;
      breq_d.single = state_d == S_SA;
      breq_d.show = !ddcr[`ACK_LAST_ONLY_SELECT] || bcr_q[ch_d] == dstep;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= S_IDLE;
         ch_q <= 2'h0;
         beat_q <= 2'h0;
         gap_q <= 8'h00;
         breq_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         ch_q <= ch_d;
         beat_q <= beat_d;
         gap_q <= gap_d;
         breq_q <= breq_d;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (state_q == S_RD && beat_ok && !bus_rsp_i.err)
         buf_q[beat_q] <= bus_rsp_i.rdata;
   end
   assign bus_req_o = breq_q;

   ////////////////////////////////////////////////////////////////////
   // Channel registers and status; hardware set wins over clear
   wire [3:0] cur_oh = 4'h1 << ch_q;
   wire [3:0] sel_oh = 4'h1 << sel;
   wire [3:0] adv = cur_oh & {4{xfer_ok}};
   wire [3:0] fin = adv & {4{blk_end}};
   wire [3:0] err_oh = cur_oh & {4{term_err}};
   wire [3:0] bad_oh = sel_oh & {4{start_bad}};
   wire [3:0] zero_oh = sel_oh & {4{start_zero}};
   wire [3:0] stop = fin | err_oh | bad_oh | zero_oh;
   wire [3:0] req_set = sw_start | trig;
   wire [3:0] req_clr = stop | (adv & {4{cs_mode}});

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         req_q <= 4'h0;
         run_q <= 4'h0;
         done_q <= 4'h0;
         ce_q <= 4'h0;
         be_q <= 4'h0;
      end
      else
      begin
         req_q <= req_set | (req_q & ~req_clr);
         run_q <= req_set | (run_q & ~stop);
         done_q <= fin | zero_oh | (done_q & ~st_clr);
         ce_q <= bad_oh | (ce_q & ~st_clr);
         be_q <= err_oh | (be_q & ~st_clr);
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         for (int c = 0; c < `NCH; c++)
         begin
            sar_q[c] <= 32'h00000000;
            dar_q[c] <= 32'h00000000;
            dcr_q[c] <= 16'h0000;
            bcr_q[c] <= 24'h000000;
         end
      else
         for (int c = 0; c < `NCH; c++)
         begin
            if (wr_sar[c])
               sar_q[c] <= pwdata_i;
            else if (adv[c] && (cdcr[`DCR_SINC] || cdcr[`DCR_SAA]))
               sar_q[c] <= sar_q[c] + {8'h00, cstep};
            if (wr_dar[c])
               dar_q[c] <= pwdata_i;
            else if (adv[c] && cdcr[`DCR_DINC] && !cdcr[`DCR_SAA])
               dar_q[c] <= dar_q[c] + {8'h00, cstep};
            // Start is an action, never stored
            if (wr_dcr[c])
               dcr_q[c] <= {pwdata_i[15:1], 1'b0};
            if (wr_bcr[c])
               bcr_q[c] <= pwdata_i[`CNT_W-1:0];
            else if (adv[c])
               bcr_q[c] <= new_bcr;
         end
   end

   ////////////////////////////////////////////////////////////////////
   // Shared pins: modifier, acknowledge or port function
   wire dcyc = breq_q.valid;
   wire show = dcyc & breq_q.show;
   assign transfer_type_pins_o = dcyc ? `TT_DMA : `TT_IDLE;
   wire tm2 = dcyc & breq_q.single;
   wire [1:0] chan_code = (show && !breq_q.chan[1]) ?
      breq_q.chan : `TM_NOCHAN;
   wire [1:0] dack = {2{show}} &
      {breq_q.chan == 2'h1, breq_q.chan == 2'h0};
   // Ack needs its modifier pin enabled first
   wire [1:0] ack_on = interrupt_pin_assignment_q & par_q[1:0];
   wire [2:0] fn_val = {tm2, (ack_on & dack) | (~ack_on & chan_code)};

   assign transfer_modifier_bits_o.o = (par_q & fn_val)
      | (~par_q & parallel_port_bits_i.o);
   assign transfer_modifier_bits_o.oe = par_q
      | (~par_q & parallel_port_bits_i.oe);

endmodule // dma_transfer_signalling

// file: inc/dma_cfg.svh
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
`define NCH 4
`define CNT_W 24
`define OFF_PAR 10'h200
`define OFF_INTERRUPT_PIN_ASSIGNMENT 10'h204
`define CH_REGION 2'h3
`define REG_SAR 4'h0
`define REG_DAR 4'h1
`define REG_DCR 4'h2
`define REG_BCR 4'h3
`define REG_DSR 4'h4
`define CHANNEL_START_BIT 0
`define DCR_EEXT 1
`define DCR_CS 2
`define ACK_LAST_ONLY_SELECT 3
`define DCR_SIZE 5:4
`define DCR_SINC 6
`define DCR_DINC 7
`define DCR_SAA 8
`define DCR_SDIR 9
`define DCR_BWC 15:12
`define DSR_DONE 0
`define DSR_BSY 1
`define DSR_CE 2
`define DSR_BE 3
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define SZ_LINE 2'h3
`define STEP_BYTE 24'h000001
`define STEP_WORD 24'h000002
`define STEP_LONG 24'h000004
`define STEP_LINE 24'h000010
`define LINE_LAST 2'h3
`define BW_PAD 4'h0
`define TT_DMA 2'h1
`define TT_IDLE 2'h0
`define TM_NOCHAN 2'h2
`define RQ_IDLE 2'h3
`endif

// file: inc/dma_pkg.sv
package dma_pkg;
   typedef enum logic [2:0] {S_IDLE, S_RD, S_WR, S_SA, S_GAP} eng_state_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0] chan;
      logic single;
      logic show;
   } bus_req_t;
   typedef struct packed {
      logic ready;
      logic err;
      logic [31:0] rdata;
   } bus_rsp_t;
   typedef struct packed {
      logic [2:0] o;
      logic [2:0] oe;
   } pin_drv_t;
endpackage

// file: verif/dma_transfer_signalling_props.sv
`timescale 1ns/10ps
module dma_transfer_signalling_props (
   input wire logic clk_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic [9:0] paddr_i, // Address
   input wire logic psel_i, // Select
   input wire logic penable_i, // Enable
   input wire logic pwrite_i, // Direction
   input wire logic [31:0] pwdata_i, // Write data
   input wire logic [31:0] prdata_o, // Read data
   input wire logic pready_o, // Ready
   input wire logic pslverr_o, // Error
   input wire dma_pkg::bus_req_t bus_req_o, // Bus request
   input wire dma_pkg::bus_rsp_t bus_rsp_i, // Bus answer
   input wire logic [1:0] dma_request_in_n_i, // Request pins
   input wire logic [1:0] periph_req_i, // On-chip requests
   input wire dma_pkg::pin_drv_t parallel_port_bits_i, // Port drive
   input wire dma_pkg::pin_drv_t transfer_modifier_bits_o, // Pins
   input wire logic [1:0] transfer_type_pins_o // Type pins
);
   import dma_pkg::*;
   logic rd_beat;
   logic par_wr;
   assign rd_beat = bus_req_o.valid && bus_rsp_i.ready && !bus_req_o.write
      && !bus_req_o.single && bus_req_o.size != 2'h3 && !bus_rsp_i.err;
   assign par_wr = psel_i && penable_i && pwrite_i && paddr_i == 10'h200;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////////////
   property p_type;
      transfer_type_pins_o == (bus_req_o.valid ? 2'h1 : 2'h0);
   endproperty
   a_type: assert property (p_type)
      else $error("type pins wrong");
   property p_single;
      bus_req_o.valid && transfer_modifier_bits_o.oe[2]
         && !parallel_port_bits_i.oe[2]
         |-> transfer_modifier_bits_o.o[2] == bus_req_o.single;
   endproperty
   a_single: assert property (p_single)
      else $error("upper modifier bit wrong");
   property p_oe_src;
      (parallel_port_bits_i.oe & ~transfer_modifier_bits_o.oe) == 3'h0;
   endproperty
   a_oe_src: assert property (p_oe_src)
      else $error("port enable dropped");
   // Pin enables may only change after a PAR write or a change of the port enables
   property p_oe_hold;
      !par_wr |=> !$stable(parallel_port_bits_i.oe)
         || $stable(transfer_modifier_bits_o.oe);
   endproperty
   a_oe_hold: assert property (p_oe_hold)
      else $error("pin enable changed unasked");
   property p_rd_wr;
      rd_beat |=> bus_req_o.valid && bus_req_o.write;
   endproperty
   a_rd_wr: assert property (p_rd_wr)
      else $error("read not followed by write");
   property p_copy;
      rd_beat |=> bus_req_o.wdata == $past(bus_rsp_i.rdata);
   endproperty
   a_copy: assert property (p_copy)
      else $error("write data differs from read");
   property p_hold;
      bus_req_o.valid && !bus_rsp_i.ready
         |=> bus_req_o.valid && $stable(bus_req_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("request changed before ready");
   property p_int_single;
      bus_req_o.valid && bus_req_o.single |-> !bus_req_o.chan[1];
   endproperty
   a_int_single: assert property (p_int_single)
      else $error("single access on internal channel");
endmodule // dma_transfer_signalling_props
bind dma_transfer_signalling dma_transfer_signalling_props i_props (
   .clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .bus_req_o(bus_req_o), .bus_rsp_i(bus_rsp_i),
   .dma_request_in_n_i(dma_request_in_n_i), .periph_req_i(periph_req_i),
   .parallel_port_bits_i(parallel_port_bits_i),
   .transfer_modifier_bits_o(transfer_modifier_bits_o),
   .transfer_type_pins_o(transfer_type_pins_o));

// file: verif/ext_bus_peer.sv
`timescale 1ns/10ps
module ext_bus_peer (
   input wire logic clk_i, // Clock
   input wire logic reset_i, // Reset
   input wire dma_pkg::bus_req_t req_i, // Bus request
   output dma_pkg::bus_rsp_t rsp_o, // Bus answer
   input wire logic [3:0] wait_i, // Stall cycles
   input wire logic [1:0] pulse_i, // Request strobes
   output logic [1:0] req_n_o // Request pins
);
   import dma_pkg::*;
   logic [3:0] cnt_q;
   logic rdy;
   logic [31:0] data;
   assign rdy = req_i.valid && cnt_q == wait_i;
   // Stalled reads show a moving pattern, never stale data
   assign data = rdy ? {req_i.addr[15:0], 16'h5AC3} : {8{cnt_q}};
   assign rsp_o = {rdy, 1'b0, data};
   assign req_n_o = ~pulse_i;
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         cnt_q <= 4'h0;
      else if (req_i.valid && !rdy)
         cnt_q <= cnt_q + 4'h1;
      else
         cnt_q <= 4'h0;
   end
endmodule // ext_bus_peer

// file: verif/dma_transfer_signalling_bench.sv
`timescale 1ns/10ps
module dma_transfer_signalling_bench;
   import dma_pkg::*;
   typedef struct {
      logic [1:0] ch;
      logic [2:0] par;
      logic [1:0] irq;
      logic [15:0] dcr;
      logic [23:0] byte_count_reg;
      logic nv;
      logic [5:0] pins;
      logic [3:0] dsr;
   } row_t;
   // Channel, PAR, ack enables, DCR, count, no transfer, {o,oe}, status
   row_t rows [13] = '{
      '{2'h1, 3'h7, 2'h0, 16'h0021, 24'h4, 1'b0, 6'h0F, 4'h1},
      '{2'h1, 3'h7, 2'h2, 16'h0021, 24'h4, 1'b0, 6'h1F, 4'h1},
      '{2'h0, 3'h7, 2'h1, 16'h0021, 24'h4, 1'b0, 6'h0F, 4'h1},
      '{2'h1, 3'h7, 2'h3, 16'h0021, 24'h4, 1'b0, 6'h17, 4'h1},
      '{2'h1, 3'h7, 2'h0, 16'h0029, 24'h8, 1'b0, 6'h17, 4'h1},
      '{2'h0, 3'h7, 2'h0, 16'h0121, 24'h4, 1'b0, 6'h27, 4'h1},
      '{2'h1, 3'h0, 2'h0, 16'h0021, 24'h4, 1'b0, 6'h28, 4'h1},
      '{2'h1, 3'h4, 2'h3, 16'h0021, 24'h4, 1'b0, 6'h0C, 4'h1},
      '{2'h3, 3'h7, 2'h0, 16'h0011, 24'h2, 1'b0, 6'h17, 4'h1},
      '{2'h0, 3'h7, 2'h0, 16'h0001, 24'h3, 1'b0, 6'h07, 4'h1},
      '{2'h1, 3'h7, 2'h0, 16'h0031, 24'h10, 1'b0, 6'h0F, 4'h1},
      '{2'h3, 3'h7, 2'h0, 16'h0021, 24'h3, 1'b1, 6'h00, 4'h4},
      '{2'h2, 3'h7, 2'h0, 16'h0121, 24'h4, 1'b1, 6'h00, 4'h4}};
   logic clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [9:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   bus_req_t bus_req_o;
   bus_rsp_t bus_rsp_i;
   pin_drv_t port_q, tm_o;
   logic [1:0] req_n, pulse_q, preq_q, tt_o;
   logic [3:0] stall_q;
   int err_total, checked;
   dma_transfer_signalling i_dma_transfer_signalling (
      .clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .bus_req_o(bus_req_o), .bus_rsp_i(bus_rsp_i),
      .dma_request_in_n_i(req_n), .periph_req_i(preq_q),
      .parallel_port_bits_i(port_q), .transfer_modifier_bits_o(tm_o),
      .transfer_type_pins_o(tt_o));
   ext_bus_peer i_ext_bus_peer (.clk_i(clk_i), .reset_i(reset_i),
      .req_i(bus_req_o), .rsp_o(bus_rsp_i), .wait_i(stall_q),
      .pulse_i(pulse_q), .req_n_o(req_n));
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d, errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got,
            exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [9:0] a,
      input logic [31:0] dw, output logic [31:0] dr, output logic er);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= dw;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk_i);
      end
      dr = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20)
      begin
         err_total++;
         report_and_stop();
      end
   endtask
   // Reads until the masked value matches, then compares once
   task automatic poll(input logic [9:0] a, input logic [31:0] m,
      input logic [31:0] x, input int lim);
      logic [31:0] d;
      logic e;
      int n;
      n = 0;
      do
      begin
         apb(1'b0, a, 32'h0, d, e);
         n++;
      end
      while ((d & m) !== x && n < lim);
      chk(d & m, x);
      if ((d & m) !== x && lim > 1)
         report_and_stop();
   endtask
   task automatic wait_valid();
      int n;
      n = 0;
      while (bus_req_o.valid !== 1'b1 && n < 100)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n >= 100)
      begin
         err_total++;
         report_and_stop();
      end
   endtask
   task automatic run_row(input row_t r);
      logic [9:0] b;
      logic [31:0] d;
      logic e;
      b = 10'h300 + {2'h0, r.ch, 6'h0};
      apb(1'b1, 10'h204, 32'h0, d, e);
      apb(1'b1, 10'h200, {29'h0, r.par}, d, e);
      apb(1'b1, 10'h204, {30'h0, r.irq}, d, e);
      apb(1'b1, b, 32'h1000, d, e);
      apb(1'b1, b + 10'h4, 32'h2000, d, e);
      apb(1'b1, b + 10'hC, {8'h0, r.byte_count_reg}, d, e);
      apb(1'b1, b + 10'h8, {16'h0, r.dcr}, d, e);
      if (!r.nv)
      begin
         wait_valid();
         chk({26'h0, tm_o}, {26'h0, r.pins});
         chk({30'h0, tt_o}, 32'h1);
      end
      poll(b + 10'h10, 32'hF, {28'h0, r.dsr}, 100);
      poll(b + 10'hC, 32'hFFFFFFFF, r.nv ? {8'h0, r.byte_count_reg} : 32'h0, 1);
      apb(1'b1, b + 10'h10, 32'h1, d, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] d;
      logic e;
      logic [9:0] ad;
      err_total = 0;
      checked = 0;
      reset_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 10'h0;
      pwdata_i = 32'h0;
      port_q = {3'h5, 3'h0};
      pulse_q = 2'h0;
      preq_q = 2'h0;
      stall_q = 4'h0;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 13; i++)
      begin
         stall_q <= 4'(i % 3);
         run_row(rows[i]);
      end
      // Cycle-steal on the pin request: one unit per request
      apb(1'b1, 10'h30C, 32'h8, d, e);
      apb(1'b1, 10'h308, 32'h26, d, e);
      pulse_q <= 2'h1;
      repeat (4) @(posedge clk_i);
      pulse_q <= 2'h0;
      poll(10'h30C, 32'hFFFFFFFF, 32'h4, 100);
      pulse_q <= 2'h1;
      repeat (4) @(posedge clk_i);
      pulse_q <= 2'h0;
      poll(10'h310, 32'hF, 32'h1, 100);
      // On-chip request for channel 2: one rising edge, one unit
      apb(1'b1, 10'h38C, 32'h4, d, e);
      apb(1'b1, 10'h388, 32'h26, d, e);
      preq_q <= 2'h1;
      @(posedge clk_i);
      preq_q <= 2'h0;
      poll(10'h390, 32'hF, 32'h1, 100);
      poll(10'h38C, 32'hFFFFFFFF, 32'h0, 1);
      apb(1'b1, 10'h38C, 32'hFFFFFFFF, d, e);
      poll(10'h38C, 32'hFFFFFFFF, 32'h00FFFFFF, 1);
      for (int k = 0; k < 4; k++)
      begin
         ad = 10'h300 + {2'h0, k[1:0], 6'h0};
         apb(1'b1, ad, {24'hA50000, 6'h0, k[1:0]}, d, e);
      end
      for (int k = 0; k < 4; k++)
      begin
         ad = 10'h300 + {2'h0, k[1:0], 6'h0};
         poll(ad, 32'hFFFFFFFF, {24'hA50000, 6'h0, k[1:0]}, 1);
      end
      apb(1'b0, 10'h100, 32'h0, d, e);
      chk({31'h0, e}, 32'h1);
      chk(d, 32'h0);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      poll(10'h200, 32'hFFFFFFFF, 32'h0, 1);
      poll(10'h38C, 32'hFFFFFFFF, 32'h0, 1);
      poll(10'h350, 32'hFFFFFFFF, 32'h0, 1);
      report_and_stop();
   end
endmodule // dma_transfer_signalling_bench
